// ===== hdl/eps_top.v
// Edge pulse sequencer top: one-shot, sequencer, event trigger and AHB-Lite registers
// Operation
// - Falling input edge drives output one high
// - Output stays high one second, then low
// - Only a falling edge starts a pulse
// - Timer runs; at one second flag forces low
// - Time-base flag inverts every half second
// - Counter advances once per flag period
// - Counter value selects one of six outputs
// - Each step: old output off, next on
// - After last output counter returns to zero
// - Event count fires action and clears together
// - Act on first occurrence, not level
`timescale 1ns/100ps
`include "eps_defs.vh"

module eps_top #(
	parameter PULSE_CYCLES = `EPS_CLK_HZ / 1000 * `EPS_PULSE_MS,
	parameter HALF_CYCLES  = `EPS_CLK_HZ / 1000 * `EPS_HALF_MS
) (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Field contacts
	input  wire [1:0]  digital_input,
	// Actuators
	output wire        pulse_out,
	output wire [5:0]  seq_out,
	output reg         event_out
);

	// ****************************************
	// Register state
	// ****************************************
	reg  [2:0]  ctrl;
	reg  [15:0] input_event_counter;
	reg  [15:0] fire_count;
	reg         prev_event_in;
	reg         dp_write;
	reg  [7:0]  dp_addr;
	wire        os_flag;
	wire        base_flag;
	wire [2:0]  step;
	wire [31:0] status;

	// ****************************************
	// Function blocks
	// ****************************************
	eps_oneshot #(
		.PULSE_CYCLES (PULSE_CYCLES)
	) u_oneshot (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.enable        (ctrl[`EPS_CTRL_ONESHOT]),
		.digital_input (digital_input[0]),
		.pulse_out     (pulse_out),
		.timer_flag    (os_flag)
	);

	eps_sequencer #(
		.HALF_CYCLES (HALF_CYCLES)
	) u_sequencer (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable    (ctrl[`EPS_CTRL_SEQ]),
		.base_flag (base_flag),
		.step      (step),
		.seq_out   (seq_out)
	);

	// ****************************************
	// Event trigger
	// ****************************************
	// Counting rising edges rather than watching the level keeps a held
	// input from firing the action over and over.
	wire event_edge = digital_input[1] & ~prev_event_in;
	wire fire       = ctrl[`EPS_CTRL_EVENT] && (input_event_counter != 16'h0);
	wire fires_clr  = dp_write && (dp_addr == `EPS_OFS_FIRES);
	wire evc_clr    = dp_write && (dp_addr == `EPS_OFS_EVCOUNT);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_event_in       <= 1'b0;
			input_event_counter <= 16'h0;
			event_out           <= 1'b0;
			fire_count          <= 16'h0;
		end else begin
			prev_event_in <= digital_input[1];
			event_out     <= fire;
			// A new edge in the clearing cycle is kept as a count of one
			if (fire || evc_clr)
				input_event_counter <= event_edge ? 16'h1 : 16'h0;
			else if (event_edge && input_event_counter != 16'hffff)
				input_event_counter <= input_event_counter + 16'h1;
			if (fire)
				fire_count <= fire_count + 16'h1;
			else if (fires_clr)
				fire_count <= 16'h0;
		end
	end

	// ****************************************
	// Status word
	// ****************************************
	assign status = {7'h0, event_out,
	                 2'h0, seq_out,
	                 5'h0, step,
	                 3'h0, base_flag, os_flag, pulse_out, digital_input};

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	// Zero wait states; read data is sampled in the address phase so it
	// reflects state one cycle before the data phase edge.
	wire take = hsel && hready && htrans[1];

	function [31:0] read_mux;
		input [7:0] a;
		begin
			case (a)
				`EPS_OFS_CTRL:    read_mux = {29'h0, ctrl};
				`EPS_OFS_STATUS:  read_mux = status;
				`EPS_OFS_EVCOUNT: read_mux = {16'h0, input_event_counter};
				`EPS_OFS_FIRES:   read_mux = {16'h0, fire_count};
				default:          read_mux = 32'h0;
			endcase
		end
	endfunction

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write  <= 1'b0;
			dp_addr   <= 8'h0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			ctrl      <= `EPS_CTRL_RESET;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			dp_write  <= take && hwrite;
			if (take)
				dp_addr <= {haddr[7:2], 2'h0};
			if (take && !hwrite)
				hrdata <= (haddr[31:8] == 24'h0) ? read_mux({haddr[7:2], 2'h0}) : 32'h0;
			if (dp_write && dp_addr == `EPS_OFS_CTRL)
				ctrl <= hwdata[2:0];
		end
	end

endmodule // eps_top

// ===== hdl/eps_defs.vh
// Constants shared by the edge pulse sequencer files
`ifndef EPS_DEFS_VH
`define EPS_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define EPS_CLK_HZ        125000000
`define EPS_PULSE_MS      1000
`define EPS_HALF_MS       500

// ****************************************
// Register byte offsets
// ****************************************
`define EPS_OFS_CTRL      8'h00
`define EPS_OFS_STATUS    8'h04
`define EPS_OFS_EVCOUNT   8'h08
`define EPS_OFS_FIRES     8'h0c

// ****************************************
// Control fields and reset value
// ****************************************
`define EPS_CTRL_ONESHOT  0
`define EPS_CTRL_SEQ      1
`define EPS_CTRL_EVENT    2
`define EPS_CTRL_RESET    3'h7

// ****************************************
// Status fields
// ****************************************
`define EPS_ST_DIN0       0
`define EPS_ST_DIN1       1
`define EPS_ST_PULSE      2
`define EPS_ST_OS_FLAG    3
`define EPS_ST_SEQ_FLAG   4
`define EPS_ST_CNT_LSB    8
`define EPS_ST_OUT_LSB    16
`define EPS_ST_EVENT      24

// ****************************************
// Sequencer
// ****************************************
`define EPS_SEQ_LAST      3'h5

`endif

// ===== hdl/eps_oneshot.v
// Falling-edge one-shot with timer and end-of-pulse flag
`timescale 1ns/100ps
`include "eps_defs.vh"

module eps_oneshot #(
	parameter PULSE_CYCLES = 125000000
) (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// Control
	input  wire        enable,
	input  wire        digital_input,
	// Results
	output reg         pulse_out,
	output reg         timer_flag
);

	reg        prev_in;
	reg        running;
	reg [31:0] timer;

	wire fall = prev_in & ~digital_input;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_in    <= 1'b1;
			running    <= 1'b0;
			timer      <= 32'h0;
			pulse_out  <= 1'b0;
			timer_flag <= 1'b0;
		end else begin
			prev_in <= digital_input;
			if (running) begin
				if (timer == PULSE_CYCLES - 1) begin
					// End of interval: flag forces the output low
					running    <= 1'b0;
					timer_flag <= 1'b1;
					pulse_out  <= 1'b0;
				end else begin
					timer <= timer + 32'h1;
				end
			end else if (enable && fall) begin
				running    <= 1'b1;
				timer      <= 32'h0;
				pulse_out  <= 1'b1;
				timer_flag <= 1'b0;
			end else if (digital_input) begin
				// Re-arm once the input is back high
				timer_flag <= 1'b0;
			end
		end
	end

endmodule // eps_oneshot

// ===== hdl/eps_sequencer.v
// Half-second time base, step counter and six-output walking sequence
`timescale 1ns/100ps
`include "eps_defs.vh"

module eps_sequencer #(
	parameter HALF_CYCLES = 62500000
) (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// Control
	input  wire        enable,
	// Results
	output reg         base_flag,
	output reg  [2:0]  step,
	output reg  [5:0]  seq_out
);

	reg  [31:0] prescale;
	wire        half_tick = (prescale == HALF_CYCLES - 1);
	wire        advance   = half_tick & ~base_flag;
	wire [2:0]  next_step = (step == `EPS_SEQ_LAST) ? 3'h0 : step + 3'h1;
	wire [5:0]  next_out;

	// Index kept as an integer so the generate index is not cut at the call
	function sel_bit;
		input [2:0]   cnt;
		input integer idx;
		begin
			sel_bit = ({29'h0, cnt} == idx);
		end
	endfunction

	genvar i;
	generate
		for (i = 0; i < 6; i = i + 1) begin : g_sel
			// Only the output matching the count is on
			assign next_out[i] = sel_bit(advance ? next_step : step, i);
		end
	endgenerate

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale  <= 32'h0;
			base_flag <= 1'b0;
			step      <= 3'h0;
			seq_out   <= 6'h0;
		end else if (!enable) begin
			// Stopped: all outputs off, restart from output zero
			prescale  <= 32'h0;
			base_flag <= 1'b0;
			step      <= 3'h0;
			seq_out   <= 6'h0;
		end else begin
			prescale <= half_tick ? 32'h0 : prescale + 32'h1;
			if (half_tick)
				base_flag <= ~base_flag;
			if (advance)
				step <= next_step;
			seq_out <= next_out;
		end
	end

endmodule // eps_sequencer

// ===== hdl/eps_pad_unused.v
// Spare design file: holds no module

// ===== sim/eps_top_properties.sv
// Concurrent checks on the edge pulse sequencer ports
`timescale 1ns/100ps
module eps_top_properties #(
	parameter PULSE_CYCLES = 20,
	parameter HALF_CYCLES  = 10
) (
	input wire       hclk,
	input wire       hresetn,
	input wire [1:0] digital_input,
	input wire       pulse_out,
	input wire [5:0] seq_out,
	input wire       event_out,
	input wire       hreadyout,
	input wire       hresp
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ****************************************
	// Helper counters
	// ****************************************
	logic [31:0] hi_cnt;
	logic [31:0] gap;
	logic [5:0]  last;
	wire  [5:0]  rot = {seq_out[4:0], seq_out[5]};
	wire         step = (seq_out != last) && (last != 6'h00) && (seq_out != 6'h00);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_cnt <= 32'h0;
			gap <= 32'h0;
			last <= 6'h00;
		end else begin
			hi_cnt <= pulse_out ? hi_cnt + 32'h1 : 32'h0;
			gap <= (seq_out != last) ? 32'h1 : gap + 32'h1;
			last <= seq_out;
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	sequence s_fall;
		digital_input[0] && !pulse_out ##1 !digital_input[0] && !pulse_out;
	endsequence
	property p_bus; hreadyout && !hresp; endproperty
	property p_start; s_fall |-> ##2 pulse_out; endproperty
	property p_only_fall; $rose(pulse_out) |-> !$past(digital_input[0]) && $past(digital_input[0], 2); endproperty
	property p_width; $fell(pulse_out) |-> hi_cnt == PULSE_CYCLES; endproperty
	property p_onehot; $onehot0(seq_out); endproperty
	property p_rotate; step |-> seq_out == $past(rot); endproperty
	property p_period; step && last != 6'h01 |-> gap == 2 * HALF_CYCLES; endproperty
	property p_event; $rose(digital_input[1]) |-> ##2 event_out; endproperty
	property p_once; event_out |=> !event_out; endproperty
	a_bus: assert property (p_bus) else $error("bus response not ready or not okay");
	a_start: assert property (p_start) else $error("falling edge gave no pulse");
	a_only_fall: assert property (p_only_fall) else $error("pulse without falling edge");
	a_width: assert property (p_width) else $error("pulse width wrong");
	a_onehot: assert property (p_onehot) else $error("more than one output on");
	a_rotate: assert property (p_rotate) else $error("sequence order wrong");
	a_period: assert property (p_period) else $error("sequence step period wrong");
	a_event: assert property (p_event) else $error("event action missing");
	a_once: assert property (p_once) else $error("event action repeated");
endmodule // eps_top_properties

// ===== sim/eps_field.sv
// Field contact model driving the digital inputs
`timescale 1ns/100ps
module eps_field (
	input  wire        hclk,
	output logic [1:0] digital_input
);
	initial digital_input = 2'h1;
	// Contacts change just after an edge, like any synchronous source
	task automatic drive(input int idx, input logic lvl);
		@(posedge hclk);
		digital_input[idx] <= lvl;
	endtask
endmodule // eps_field

// ===== sim/eps_top_bench.sv
// Self-checking bench for the edge pulse sequencer
`timescale 1ns/100ps
module eps_top_bench;
	localparam PULSE = 20;
	localparam HALF = 10;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	wire [31:0] hrdata;
	wire hreadyout, hresp, pulse_out, event_out;
	wire [5:0] seq_out;
	wire [1:0] digital_input;
	int error_cnt = 0, n_checks = 0;
	always #4 hclk = ~hclk;
	eps_field field (.hclk(hclk), .digital_input(digital_input));
	eps_top #(.PULSE_CYCLES(PULSE), .HALF_CYCLES(HALF)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .digital_input(digital_input),
		.pulse_out(pulse_out), .seq_out(seq_out), .event_out(event_out));
	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task end_sim;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		ahb(0, 32'h0, 0);
		chk("ctrl", rd, 32'h7);
		ahb(0, 32'h10, 0);
		chk("unmapped", rd, 32'h0);
	endtask
	task t_oneshot;
		int n;
		field.drive(0, 1'b0);
		for (n = 0; n < 5 && pulse_out !== 1'b1; n++) @(posedge hclk);
		chk("pulse_rise", pulse_out, 1);
		for (n = 0; n < 100 && pulse_out === 1'b1; n++) @(posedge hclk);
		chk("pulse_len", n, PULSE);
		repeat (40) @(posedge hclk);
		chk("held_low", pulse_out, 0);
		ahb(0, 32'h4, 0);
		chk("os_flag_set", rd[3], 1);
		field.drive(0, 1'b1);
		repeat (3) @(posedge hclk);
		ahb(0, 32'h4, 0);
		chk("os_flag_clr", rd[3], 0);
		field.drive(0, 1'b0);
		for (n = 0; n < 5 && pulse_out !== 1'b1; n++) @(posedge hclk);
		chk("pulse_again", pulse_out, 1);
	endtask
	task t_seq;
		logic [5:0] exp;
		int n, k;
		ahb(1, 32'h0, 32'h5);
		repeat (3) @(posedge hclk);
		chk("seq_off", seq_out, 0);
		ahb(1, 32'h0, 32'h7);
		for (n = 0; n < 5 && seq_out !== 6'h01; n++) @(posedge hclk);
		chk("seq_first", seq_out, 6'h01);
		// Seven steps so the walk wraps back past the last output
		exp = 6'h01;
		for (k = 0; k < 7; k++) begin
			exp = {exp[4:0], exp[5]};
			for (n = 0; n < 3 * HALF && seq_out === {exp[0], exp[5:1]}; n++) @(posedge hclk);
			chk("seq_step", seq_out, exp);
			// The first output after enable stands only half a period
			if (k > 0) chk("seq_period", n, 2 * HALF);
		end
	endtask
	task t_event;
		int fires;
		fires = 0;
		field.drive(1, 1'b1);
		repeat (30) begin
			@(posedge hclk);
			if (event_out === 1'b1) fires++;
		end
		chk("fires", fires, 1);
		ahb(0, 32'h8, 0);
		chk("evcount", rd, 0);
		ahb(0, 32'hc, 0);
		chk("fire_cnt", rd, 1);
		ahb(1, 32'hc, 0);
		ahb(0, 32'hc, 0);
		chk("fire_clr", rd, 0);
		field.drive(1, 1'b0);
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_oneshot();
		t_seq();
		t_event();
		end_sim();
	end
	// The whole run is a few hundred cycles; this margin only catches a hang
	initial begin
		#(8 * 20000);
		error_cnt++;
		end_sim();
	end
endmodule // eps_top_bench
bind eps_top eps_top_properties #(.PULSE_CYCLES(PULSE_CYCLES), .HALF_CYCLES(HALF_CYCLES)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .digital_input(digital_input), .pulse_out(pulse_out), .seq_out(seq_out),
	.event_out(event_out), .hreadyout(hreadyout), .hresp(hresp));
